// ==== core/pfl_pkg.sv ====
package pfl_pkg;
	localparam int N_ENT = 8;
	localparam int IDX_W = 3;
	localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
	localparam logic [3:0] MISS_LAST = 4'h7;

	typedef struct packed {
		logic valid;
		logic live;
		logic [7:0] kind;
		logic [7:0] loc;
		logic [15:0] count;
		logic [31:0] dur;
	} pfl_entry_t;

	typedef struct packed {
		logic pass_end;
		logic [7:0] kind;
		logic [7:0] loc;
	} pfl_diag_t;

	typedef struct packed {
		logic valid;
		logic live;
		logic [7:0] kind;
		logic [7:0] loc;
	} pfl_view_t;

	typedef struct packed {
		pfl_entry_t [N_ENT-1:0] arr;
		pfl_entry_t rdata;
	} pfl_mem_state_t;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_VIEW = 8'h10;
	localparam logic [7:0] REG_VIEW_CNT = 8'h14;
	localparam logic [7:0] REG_VIEW_DUR = 8'h18;
	localparam int CTRL_CLEAR = 0;

	localparam int IRQ_W = 3;
	localparam int IRQ_NEW = 0;
	localparam int IRQ_CLR = 1;
	localparam int IRQ_FULL = 2;

	localparam logic [1:0] SUM_EMPTY = 2'h0;
	localparam logic [1:0] SUM_INACTIVE = 2'h1;
	localparam logic [1:0] SUM_LIVE = 2'h2;

	localparam int CLK_NS = 100;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam int DWELL_MS = 500;
	localparam logic [15:0] DWELL_TICKS = 16'(DWELL_MS * 1000000 / TICK_NS);

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_RD = 4'h2,
		S_EV = 4'h4,
		S_PUT = 4'h8
	} pfl_state_t;

	typedef enum logic [4:0] {
		J_RESCAN = 5'h01,
		J_CLEAR = 5'h02,
		J_FIND = 5'h04,
		J_PASS = 5'h08,
		J_ROT = 5'h10
	} pfl_job_t;
endpackage

// ==== core/pfl_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfl_mem (
	input wire logic pclk,
	input wire logic we,
	input wire logic [pfl_pkg::IDX_W-1:0] waddr,
	input wire pfl_pkg::pfl_entry_t wdata,
	input wire logic [pfl_pkg::IDX_W-1:0] raddr,
	output pfl_pkg::pfl_entry_t rdata
);
	pfl_pkg::pfl_mem_state_t s_q, s_d;

	// Stands in for non-volatile cells: no reset, so presetn never erases them
	always_comb begin
		s_d = s_q;
		if (we) begin
			s_d.arr[waddr] = wdata;
		end
		s_d.rdata = s_q.arr[raddr];
	end

	always_ff @(posedge pclk) begin
		s_q <= s_d;
	end

	assign rdata = s_q.rdata;
endmodule // pfl_mem
`default_nettype wire

// ==== core/pfl_top.sv ====
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pfl_top #(
	parameter int unsigned TICK_CYCLES = pfl_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic diag_valid,
	input wire pfl_pkg::pfl_diag_t diag,
	output logic diag_ready,
	input wire logic fw_update,
	output logic [1:0] summary,
	output pfl_pkg::pfl_view_t rot_view
);
	typedef struct packed {
		pfl_pkg::pfl_state_t st;
		pfl_pkg::pfl_job_t job;
		logic [pfl_pkg::IDX_W-1:0] idx;
		logic [pfl_pkg::N_ENT-1:0] seen;
		logic hit;
		logic [pfl_pkg::IDX_W-1:0] hit_idx;
		pfl_pkg::pfl_entry_t hit_ent;
		logic free_ok;
		logic [pfl_pkg::IDX_W-1:0] free_idx;
		pfl_pkg::pfl_diag_t req;
		logic any_v;
		logic any_l;
		logic [1:0] summary;
		logic [31:0] tick_cnt;
		logic [31:0] elapsed;
		logic [31:0] pass_elapsed;
		logic [15:0] dwell;
		logic rot_due;
		logic [3:0] rot_miss;
		logic [pfl_pkg::IDX_W-1:0] rot_idx;
		pfl_pkg::pfl_entry_t rot;
		logic clr_pend;
		logic fw_s1;
		logic fw_s2;
		logic fw_prev;
		logic [pfl_pkg::IRQ_W-1:0] irq_stat;
		logic [pfl_pkg::IRQ_W-1:0] irq_mask;
		logic irq;
		logic diag_ready;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pfl_top_state_t;

	pfl_top_state_t s_q, s_d;
	logic mem_we;
	logic [pfl_pkg::IDX_W-1:0] mem_waddr;
	pfl_pkg::pfl_entry_t mem_wdata;
	pfl_pkg::pfl_entry_t mem_rdata;

	pfl_mem u_mem (
		.pclk(pclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(s_q.idx),
		.rdata(mem_rdata)
	);

	always_comb begin
		logic tick;
		logic access;
		logic wr_now;
		logic mapped;
		logic [pfl_pkg::IRQ_W-1:0] irq_set;
		logic [pfl_pkg::IRQ_W-1:0] irq_w1c;
		logic sweep_done;
		pfl_pkg::pfl_entry_t e;
		tick = 1'b0;
		access = psel & penable;
		wr_now = access & pwrite & s_q.pready;
		mapped = 1'b0;
		irq_set = '0;
		irq_w1c = '0;
		sweep_done = (s_q.idx == pfl_pkg::IDX_LAST);
		e = mem_rdata;
		s_d = s_q;
		mem_we = 1'b0;
		mem_waddr = s_q.idx;
		mem_wdata = mem_rdata;

		// Millisecond time base for durations and the dwell timer
		if (s_q.tick_cnt == TICK_CYCLES - 1) begin
			s_d.tick_cnt = '0;
			tick = 1'b1;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 32'h1;
		end
		s_d.elapsed = s_q.elapsed + {31'h0, tick};
		if (tick) begin
			if (s_q.dwell == pfl_pkg::DWELL_TICKS - 16'h1) begin
				s_d.dwell = '0;
				s_d.rot_due = 1'b1;
			end else begin
				s_d.dwell = s_q.dwell + 16'h1;
			end
		end

		// Firmware update request arrives from outside: two flops first
		s_d.fw_s1 = fw_update;
		s_d.fw_s2 = s_q.fw_s1;
		s_d.fw_prev = s_q.fw_s2;
		if (s_q.fw_s2 && !s_q.fw_prev) begin
			s_d.clr_pend = 1'b1;
		end

		// APB slave: one wait state so that read data leave a flop
		s_d.pready = access & ~s_q.pready;
		s_d.pslverr = 1'b0;
		case (paddr)
			pfl_pkg::REG_CTRL,
			pfl_pkg::REG_STATUS,
			pfl_pkg::REG_IRQ_STAT,
			pfl_pkg::REG_IRQ_MASK,
			pfl_pkg::REG_VIEW,
			pfl_pkg::REG_VIEW_CNT,
			pfl_pkg::REG_VIEW_DUR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		if (access && !s_q.pready) begin
			s_d.pslverr = ~mapped;
			s_d.prdata = '0;
			if (!pwrite) begin
				case (paddr)
					pfl_pkg::REG_STATUS: s_d.prdata = {28'h0, s_q.clr_pend,
						(s_q.st != pfl_pkg::S_IDLE), s_q.summary};
					pfl_pkg::REG_IRQ_STAT: s_d.prdata = {29'h0, s_q.irq_stat};
					pfl_pkg::REG_IRQ_MASK: s_d.prdata = {29'h0, s_q.irq_mask};
					pfl_pkg::REG_VIEW: s_d.prdata = {11'h0, s_q.rot_idx, s_q.rot.valid,
						s_q.rot.live, s_q.rot.kind, s_q.rot.loc};
					pfl_pkg::REG_VIEW_CNT: s_d.prdata = {16'h0, s_q.rot.count};
					pfl_pkg::REG_VIEW_DUR: s_d.prdata = s_q.rot.dur;
					default: s_d.prdata = '0;
				endcase
			end
		end
		if (wr_now && !s_q.pslverr) begin
			case (paddr)
				pfl_pkg::REG_CTRL: begin
					if (pwdata[pfl_pkg::CTRL_CLEAR]) begin
						s_d.clr_pend = 1'b1;
					end
				end
				pfl_pkg::REG_IRQ_STAT: irq_w1c = pwdata[pfl_pkg::IRQ_W-1:0];
				pfl_pkg::REG_IRQ_MASK: s_d.irq_mask = pwdata[pfl_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end

		case (s_q.st)
			pfl_pkg::S_IDLE: begin
				s_d.idx = '0;
				s_d.any_v = 1'b0;
				s_d.any_l = 1'b0;
				if (diag_valid && s_q.diag_ready) begin
					s_d.req = diag;
					s_d.st = pfl_pkg::S_RD;
					if (diag.pass_end) begin
						s_d.job = pfl_pkg::J_PASS;
						s_d.pass_elapsed = s_q.elapsed + {31'h0, tick};
						s_d.elapsed = '0;
					end else begin
						s_d.job = pfl_pkg::J_FIND;
						s_d.hit = 1'b0;
						s_d.free_ok = 1'b0;
					end
				end else if (s_q.clr_pend) begin
					s_d.job = pfl_pkg::J_CLEAR;
					s_d.st = pfl_pkg::S_RD;
				end else if (s_q.rot_due) begin
					s_d.rot_due = 1'b0;
					s_d.rot_miss = '0;
					s_d.idx = s_q.rot_idx + 3'h1;
					s_d.job = pfl_pkg::J_ROT;
					s_d.st = pfl_pkg::S_RD;
				end
			end
			pfl_pkg::S_RD: begin
				if (s_q.job == pfl_pkg::J_CLEAR) begin
					mem_we = 1'b1;
					mem_wdata = '0;
					s_d.idx = s_q.idx + 3'h1;
					if (sweep_done) begin
						s_d.clr_pend = 1'b0;
						s_d.seen = '0;
						s_d.summary = pfl_pkg::SUM_EMPTY;
						s_d.rot = '0;
						irq_set[pfl_pkg::IRQ_CLR] = 1'b1;
						s_d.st = pfl_pkg::S_IDLE;
					end
				end else begin
					s_d.st = pfl_pkg::S_EV;
				end
			end
			pfl_pkg::S_EV: begin
				s_d.st = pfl_pkg::S_RD;
				s_d.idx = s_q.idx + 3'h1;
				case (s_q.job)
					pfl_pkg::J_RESCAN: begin
						e.live = 1'b0;
						mem_we = 1'b1;
						mem_wdata = e;
						s_d.any_v = s_q.any_v | e.valid;
					end
					pfl_pkg::J_PASS: begin
						if (e.valid) begin
							if (e.live) begin
								e.dur = e.dur + s_q.pass_elapsed;
							end
							e.live = s_q.seen[s_q.idx];
						end
						mem_we = 1'b1;
						mem_wdata = e;
						s_d.seen[s_q.idx] = 1'b0;
						s_d.any_v = s_q.any_v | e.valid;
						s_d.any_l = s_q.any_l | (e.valid & e.live);
					end
					pfl_pkg::J_FIND: begin
						if (e.valid && e.kind == s_q.req.kind && e.loc == s_q.req.loc) begin
							s_d.hit = 1'b1;
							s_d.hit_idx = s_q.idx;
							s_d.hit_ent = e;
						end else if (!e.valid && !s_q.free_ok) begin
							s_d.free_ok = 1'b1;
							s_d.free_idx = s_q.idx;
						end
						if (sweep_done) begin
							s_d.st = pfl_pkg::S_PUT;
						end
					end
					default: begin
						// Rotation: skip empty slots, give up after one full lap
						if (e.valid) begin
							s_d.rot = e;
							s_d.rot_idx = s_q.idx;
							s_d.st = pfl_pkg::S_IDLE;
						end else if (s_q.rot_miss == pfl_pkg::MISS_LAST) begin
							s_d.rot = '0;
							s_d.st = pfl_pkg::S_IDLE;
						end else begin
							s_d.rot_miss = s_q.rot_miss + 4'h1;
						end
					end
				endcase
				if (sweep_done && s_q.job == pfl_pkg::J_RESCAN) begin
					s_d.st = pfl_pkg::S_IDLE;
					s_d.summary = s_d.any_v ? pfl_pkg::SUM_INACTIVE : pfl_pkg::SUM_EMPTY;
				end
				if (sweep_done && s_q.job == pfl_pkg::J_PASS) begin
					s_d.st = pfl_pkg::S_IDLE;
					s_d.summary = s_d.any_l ? pfl_pkg::SUM_LIVE :
						(s_d.any_v ? pfl_pkg::SUM_INACTIVE : pfl_pkg::SUM_EMPTY);
				end
			end
			pfl_pkg::S_PUT: begin
				s_d.st = pfl_pkg::S_IDLE;
				e = s_q.hit_ent;
				if (s_q.hit) begin
					if (!e.live) begin
						e.count = e.count + 16'h1;
					end
					mem_waddr = s_q.hit_idx;
				end else begin
					e = '0;
					e.valid = 1'b1;
					e.kind = s_q.req.kind;
					e.loc = s_q.req.loc;
					e.count = 16'h1;
					mem_waddr = s_q.free_idx;
					irq_set[pfl_pkg::IRQ_NEW] = s_q.free_ok;
				end
				e.live = 1'b1;
				if (s_q.hit || s_q.free_ok) begin
					mem_we = 1'b1;
					mem_wdata = e;
					s_d.seen[mem_waddr] = 1'b1;
					s_d.summary = pfl_pkg::SUM_LIVE;
				end else begin
					// Log full: the report is dropped rather than evicting history
					irq_set[pfl_pkg::IRQ_FULL] = 1'b1;
				end
			end
			default: s_d.st = pfl_pkg::S_IDLE;
		endcase

		s_d.diag_ready = (s_d.st == pfl_pkg::S_IDLE) && !s_d.clr_pend;
		// A new event beats a same-cycle write-one-to-clear
		s_d.irq_stat = (s_q.irq_stat & ~irq_w1c) | irq_set;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.st <= pfl_pkg::S_RD;
			s_q.job <= pfl_pkg::J_RESCAN;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign irq = s_q.irq;
	assign diag_ready = s_q.diag_ready;
	assign summary = s_q.summary;
	assign rot_view = {s_q.rot.valid, s_q.rot.live, s_q.rot.kind, s_q.rot.loc};
endmodule // pfl_top
`default_nettype wire

// ==== sim/pfl_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfl_top_assertions #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic diag_valid,
	input wire pfl_pkg::pfl_diag_t diag,
	input wire logic diag_ready,
	input wire logic fw_update,
	input wire logic [1:0] summary,
	input wire pfl_pkg::pfl_view_t rot_view
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sum_range_a: assert property (summary != 2'h3)
		else $error("summary code out of range");
	first_report_a: assert property (summary == pfl_pkg::SUM_EMPTY && diag_valid && diag_ready
		&& !diag.pass_end |-> ##[1:40] summary == pfl_pkg::SUM_LIVE)
		else $error("report into empty log did not show live");
	live_valid_a: assert property (rot_view.live |-> rot_view.valid)
		else $error("live shown without entry");
	idle_view_a: assert property (!rot_view.valid |-> rot_view == '0)
		else $error("empty view not zero");
	fw_clear_a: assert property ($rose(fw_update) |-> ##[1:60] summary == pfl_pkg::SUM_EMPTY)
		else $error("firmware update did not empty log");
	diag_take_a: assert property (diag_valid && diag_ready |=> !diag_ready)
		else $error("diag ready held after take");
	access_ans_a: assert property ($rose(penable) && psel |=> pready)
		else $error("no answer one cycle into access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule // pfl_top_assertions
bind pfl_top pfl_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_pfl_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .diag_valid, .diag,
	.diag_ready, .fw_update, .summary, .rot_view);
`default_nettype wire

// ==== sim/pfl_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfl_host (
	input wire logic pclk,
	input wire pfl_pkg::pfl_view_t rot_view,
	output logic [7:0] n_seen
);
	// Watches only the shared outputs, as a measurement tool would
	logic [65535:0] seen = '0;
	logic [7:0] cnt = 8'h00;
	always @(posedge pclk) begin
		if (rot_view.valid && !seen[{rot_view.kind, rot_view.loc}]) begin
			seen[{rot_view.kind, rot_view.loc}] <= 1'b1;
			cnt <= cnt + 8'h01;
		end
	end
	assign n_seen = cnt;
endmodule // pfl_host
`default_nettype wire

// ==== sim/pfl_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module pfl_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic diag_valid = 1'b0;
	pfl_pkg::pfl_diag_t diag = '0;
	logic diag_ready;
	logic fw_update = 1'b0;
	logic [1:0] summary;
	pfl_pkg::pfl_view_t rot_view;
	logic [7:0] n_seen;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] e;
	logic [31:0] m;
	logic [15:0] key_a;
	int n_fail = 0;
	int total_checks = 0;
	always #50 pclk = ~pclk;
	pfl_top #(.TICK_CYCLES(10)) u_pfl_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq, .diag_valid, .diag, .diag_ready, .fw_update,
		.summary, .rot_view);
	pfl_host u_pfl_host (.pclk, .rot_view, .n_seen);
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Note is queued before the request so the monitor never sees an answer first
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] k);
		if (!wr) begin
			exp_q.push_back(d);
			msk_q.push_back(k);
		end
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never reassigns psel in the same step
		@(posedge pclk);
	endtask
	task automatic rep(input logic pe, input logic [15:0] key);
		diag_valid <= 1'b1;
		diag <= {pe, key};
		do @(posedge pclk); while (diag_ready !== 1'b1);
		diag_valid <= 1'b0;
		repeat (2) @(posedge pclk);
		while (diag_ready !== 1'b1) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			chk("pslverr", 32'(pslverr), 32'(!(paddr inside {pfl_pkg::REG_CTRL,
				pfl_pkg::REG_STATUS, pfl_pkg::REG_IRQ_STAT, pfl_pkg::REG_IRQ_MASK,
				pfl_pkg::REG_VIEW, pfl_pkg::REG_VIEW_CNT, pfl_pkg::REG_VIEW_DUR})));
		end
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk("prdata", prdata & m, e);
		end
	end
	initial begin
		void'($urandom(32'h190a));
		key_a = 16'($urandom());
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, pfl_pkg::REG_CTRL, 32'h1, 32'h0);
		repeat (100) @(posedge pclk);
		chk("summary", 32'(summary), 32'h0);
		apb(1'b0, pfl_pkg::REG_STATUS, 32'h0, 32'h3);
		apb(1'b0, 8'h40, 32'h0, 32'hffffffff);
		chk("irq", 32'(irq), 32'h0);
		apb(1'b1, pfl_pkg::REG_IRQ_MASK, 32'h2, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", 32'(irq), 32'h1);
		apb(1'b1, pfl_pkg::REG_IRQ_STAT, 32'h7, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", 32'(irq), 32'h0);
		rep(1'b0, key_a);
		chk("summary", 32'(summary), 32'h2);
		rep(1'b1, 16'h0);
		rep(1'b1, 16'h0);
		chk("summary", 32'(summary), 32'h1);
		rep(1'b0, key_a);
		rep(1'b1, 16'h0);
		repeat (5100) @(posedge pclk);
		apb(1'b0, pfl_pkg::REG_VIEW_CNT, 32'h2, 32'hffff);
		apb(1'b0, pfl_pkg::REG_VIEW, {14'h0, 2'b11, key_a}, 32'h3ffff);
		rep(1'b0, key_a);
		// Power cycle with a live entry: stored, but no longer live
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		chk("summary", 32'(summary), 32'h1);
		rep(1'b0, key_a ^ 16'h0100);
		rep(1'b1, 16'h0);
		chk("summary", 32'(summary), 32'h2);
		repeat (10100) @(posedge pclk);
		chk("shown", 32'(n_seen), 32'h2);
		apb(1'b0, pfl_pkg::REG_VIEW, {11'h0, 3'h0, 2'b10, key_a}, 32'h1fffff);
		fw_update <= 1'b1;
		repeat (60) @(posedge pclk);
		fw_update <= 1'b0;
		chk("summary", 32'(summary), 32'h0);
		finish_test();
	end
	initial begin
		#(100 * 40000);
		n_fail++;
		finish_test();
	end
endmodule // pfl_top_tb
`default_nettype wire
